// ===== ara_axis_ref.sv
// axis referencing: set reference point, absolute encoder adjustment, apb registers
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module ara_axis_ref
  import ara_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [DATA_W-1:0] encoder_position,
  input wire logic encoder_overflow,
  input wire logic position_value_valid,
  input wire logic set_reference_point_input,
  input wire logic traverse_active,
  input wire logic intermediate_stop,
  input wire logic [DATA_W-1:0] reference_coordinate_input,
  input wire logic [DATA_W-1:0] position_setpoint_in,
  input wire logic zero_mark_distance_coded,
  input wire logic [DATA_W-1:0] nv_offset_in,
  input wire logic nv_adjusted_in,
  output logic [DATA_W-1:0] actual_position_value,
  output logic [DATA_W-1:0] position_setpoint,
  output logic position_correction_trigger,
  output logic [DATA_W-1:0] position_correction_value,
  output logic reference_point_set_flag,
  output logic save_adjustment_alarm,
  output logic reference_outside_range_fault,
  output logic approach_active_mode,
  output logic flying_referencing_mode,
  output logic use_reference_cam,
  output logic use_external_zero_mark,
  output logic zero_mark_source_valid,
  output logic nv_store,
  output logic [DATA_W-1:0] nv_offset_out,
  output logic nv_adjusted_out
);
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [ZM_W-1:0] zero_mark_sel;
    logic [DATA_W-1:0] coord_setting;
    logic [1:0] adj_cmd;
    logic [DATA_W-1:0] ref_shift;
    logic [DATA_W-1:0] setpoint_shift;
    logic [1:0] overflows;
    logic ref_set;
    logic alarm;
    logic fault;
    logic lost;
    logic set_in_d;
    logic [DATA_W-1:0] actual;
    logic [DATA_W-1:0] setpoint;
    logic corr_trig;
    logic [DATA_W-1:0] corr_value;
    logic approach;
    logic flying;
    logic cam;
    logic ext_zm;
    logic zm_valid;
    logic nv_store;
    logic [DATA_W-1:0] nv_offset;
    logic nv_adjusted;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } ara_state_s;

  ara_state_s st;
  ara_state_s next_st;

  logic [DATA_W-1:0] img_offset;
  logic img_adjusted;
  logic img_loaded;

  ara_nv_image u_nv_image (
    .clock(clock),
    .rstn(rstn),
    .nv_offset_in(nv_offset_in),
    .nv_adjusted_in(nv_adjusted_in),
    .store(st.nv_store),
    .store_offset(st.nv_offset),
    .store_adjusted(st.nv_adjusted),
    .offset(img_offset),
    .adjusted(img_adjusted),
    .loaded(img_loaded)
  );

  logic [DATA_W-1:0] coord;
  logic [DATA_W-1:0] base_pos;
  logic [DATA_W-1:0] cur_actual;
  logic set_edge;
  logic set_allowed;
  logic in_restore;
  logic wr;
  logic rd_setup;
  logic [DATA_W-1:0] rdata;
  logic unmapped;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] new_offset;

  always_comb begin
    next_st = st;
    next_st.corr_trig = 1'b0;
    next_st.nv_store = 1'b0;

    // coordinate source: stored setting by default, controller on request
    coord = st.ctrl[CTRL_EXT_COORD_BIT] ? reference_coordinate_input
                                        : st.coord_setting;
    base_pos = encoder_position + img_offset;
    cur_actual = base_pos + st.ref_shift;

    // only an edge seen while preconditions hold acts; nothing is queued
    set_edge = set_reference_point_input && !st.set_in_d;
    set_allowed = (!traverse_active || intermediate_stop)
                  && position_value_valid;
    next_st.set_in_d = set_reference_point_input;

    // adjustment always works from the stored coordinate setting
    in_restore = ($signed(st.coord_setting) >= -RESTORE_HALF)
                 && ($signed(st.coord_setting) < RESTORE_HALF);
    new_offset = st.coord_setting - encoder_position;

    wr = psel && penable && st.pready && pwrite;
    rd_setup = psel && !penable;

    if (set_edge && set_allowed) begin
      // shift actual to the coordinate; setpoint follows by the same amount
      next_st.ref_shift = coord - base_pos;
      next_st.setpoint_shift = st.setpoint_shift + (coord - cur_actual);
      next_st.corr_trig = 1'b1;
      next_st.corr_value = coord - cur_actual;
      next_st.ref_set = 1'b1;
    end

    // overflow counting within the rotary restore range
    if (encoder_overflow && !st.ctrl[CTRL_LINEAR_BIT]
        && !st.ctrl[CTRL_TRACK_BIT]) begin
      if (st.overflows > MAX_OVERFLOWS) begin
        next_st.overflows = st.overflows;
      end else begin
        next_st.overflows = st.overflows + 2'h1;
      end
    end
    if (img_loaded && img_adjusted && !st.lost && st.overflows > MAX_OVERFLOWS) begin
      // too many overflows: adjustment is lost and the loss is stored
      next_st.lost = 1'b1;
      next_st.adj_cmd = ADJ_IDLE;
      next_st.ref_set = 1'b0;
      next_st.nv_store = 1'b1;
      next_st.nv_offset = img_offset;
      next_st.nv_adjusted = 1'b0;
    end

    // register writes
    if (wr) begin
      unique case (paddr)
        OFS_CTRL: begin
          next_st.ctrl = pwdata[CTRL_W-1:0];
          if (pwdata[CTRL_SAVE_BIT]) begin
            // save acknowledged by software clears the alarm
            next_st.alarm = 1'b0;
          end
        end
        OFS_ZERO_MARK: begin
          next_st.zero_mark_sel = pwdata[ZM_W-1:0];
        end
        OFS_COORD_SETTING: begin
          next_st.coord_setting = pwdata;
        end
        OFS_ADJ_CMD: begin
          if (pwdata[1:0] == ADJ_START) begin
            if (st.ctrl[CTRL_LINEAR_BIT] || in_restore) begin
              next_st.adj_cmd = ADJ_VALID;
              next_st.ref_set = 1'b1;
              next_st.alarm = 1'b1;
              next_st.fault = 1'b0;
              next_st.lost = 1'b0;
              next_st.overflows = 2'h0;
              next_st.ref_shift = '0;
              next_st.nv_store = 1'b1;
              next_st.nv_offset = new_offset;
              next_st.nv_adjusted = 1'b1;
            end else begin
              next_st.adj_cmd = ADJ_IDLE;
              next_st.fault = 1'b1;
            end
          end else begin
            next_st.adj_cmd = pwdata[1:0];
            next_st.fault = 1'b0;
          end
        end
        OFS_ADJ_OFFSET: begin
          next_st.nv_store = 1'b1;
          next_st.nv_offset = pwdata;
          next_st.nv_adjusted = img_adjusted;
        end
        default: begin
          next_st.ctrl = st.ctrl;
        end
      endcase
    end

    // an adjusted image restored at power-up marks the reference as set
    if (img_loaded && img_adjusted && st.adj_cmd == ADJ_IDLE && !st.lost
        && !st.fault) begin
      next_st.adj_cmd = ADJ_VALID;
      next_st.ref_set = 1'b1;
    end

    next_st.actual = cur_actual;
    next_st.setpoint = position_setpoint_in + st.setpoint_shift;
    next_st.approach = !st.ctrl[CTRL_TYPE_BIT];
    next_st.flying = st.ctrl[CTRL_TYPE_BIT];
    next_st.cam = !st.ctrl[CTRL_TYPE_BIT] && st.ctrl[CTRL_CAM_BIT];
    next_st.ext_zm = st.zero_mark_sel != ZM_RESET;
    next_st.zm_valid = !zero_mark_distance_coded;

    status_word = '0;
    status_word[ST_ALARM_BIT] = st.alarm;
    status_word[ST_FAULT_BIT] = st.fault;
    status_word[ST_VALID_BIT] = position_value_valid;
    status_word[ST_EXT_ZM_BIT] = st.ext_zm;
    status_word[ST_DIST_CODED_BIT] = !st.zm_valid;
    status_word[ST_LOST_BIT] = st.lost;
    status_word[ST_REF_SET_BIT] = st.ref_set;

    // read data and error decided in the setup cycle, answered next cycle
    unmapped = 1'b0;
    rdata = '0;
    unique case (paddr)
      OFS_CTRL: rdata = {{(DATA_W-CTRL_W){1'b0}}, st.ctrl};
      OFS_ZERO_MARK: rdata = {{(DATA_W-ZM_W){1'b0}}, st.zero_mark_sel};
      OFS_COORD_SETTING: rdata = st.coord_setting;
      OFS_ADJ_CMD: rdata = {{(DATA_W-2){1'b0}}, st.adj_cmd};
      OFS_ADJ_OFFSET: rdata = img_offset;
      OFS_STATUS: rdata = status_word;
      OFS_ACTUAL: rdata = st.actual;
      OFS_SETPOINT: rdata = st.setpoint;
      OFS_CORR: rdata = st.corr_value;
      default: unmapped = 1'b1;
    endcase
    next_st.pready = rd_setup;
    if (rd_setup) begin
      next_st.prdata = pwrite ? '0 : rdata;
      next_st.pslverr = unmapped || (pwrite && (paddr == OFS_STATUS
                        || paddr == OFS_ACTUAL || paddr == OFS_SETPOINT
                        || paddr == OFS_CORR));
    end else if (!psel) begin
      next_st.prdata = '0;
      next_st.pslverr = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign actual_position_value = st.actual;
  assign position_setpoint = st.setpoint;
  assign position_correction_trigger = st.corr_trig;
  assign position_correction_value = st.corr_value;
  assign reference_point_set_flag = st.ref_set;
  assign save_adjustment_alarm = st.alarm;
  assign reference_outside_range_fault = st.fault;
  assign approach_active_mode = st.approach;
  assign flying_referencing_mode = st.flying;
  assign use_reference_cam = st.cam;
  assign use_external_zero_mark = st.ext_zm;
  assign zero_mark_source_valid = st.zm_valid;
  assign nv_store = st.nv_store;
  assign nv_offset_out = st.nv_offset;
  assign nv_adjusted_out = st.nv_adjusted;
endmodule

// ===== ara_pkg.sv
// shared constants for the axis referencing and adjustment block
package ara_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ZERO_MARK = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COORD_SETTING = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ADJ_CMD = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_ADJ_OFFSET = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_ACTUAL = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_SETPOINT = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_CORR = 8'h20;
  // control register fields
  localparam int CTRL_TYPE_BIT = 0;
  localparam int CTRL_CAM_BIT = 1;
  localparam int CTRL_TRACK_BIT = 2;
  localparam int CTRL_EXT_COORD_BIT = 3;
  localparam int CTRL_LINEAR_BIT = 4;
  localparam int CTRL_SAVE_BIT = 5;
  localparam int CTRL_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
  // status register fields
  localparam int ST_ALARM_BIT = 0;
  localparam int ST_FAULT_BIT = 1;
  localparam int ST_VALID_BIT = 2;
  localparam int ST_EXT_ZM_BIT = 3;
  localparam int ST_DIST_CODED_BIT = 4;
  localparam int ST_LOST_BIT = 5;
  localparam int ST_REF_SET_BIT = 11;
  // adjustment command codes
  localparam logic [1:0] ADJ_IDLE = 2'h0;
  localparam logic [1:0] ADJ_START = 2'h2;
  localparam logic [1:0] ADJ_VALID = 2'h3;
  localparam int ZM_W = 8;
  localparam logic [ZM_W-1:0] ZM_RESET = 8'h00;
  localparam logic [DATA_W-1:0] COORD_RESET = 32'h0000_0000;
  // rotary encoder range in position units; restore range is half of it around zero
  localparam logic signed [DATA_W-1:0] ENC_RANGE = 32'sh0100_0000;
  localparam logic signed [DATA_W-1:0] RESTORE_HALF = ENC_RANGE >>> 2;
  localparam logic [1:0] MAX_OVERFLOWS = 2'h1;
endpackage

// ===== ara_nv_image.sv
// retained image of the adjustment offset and adjusted state
`timescale 1ns/1ps
module ara_nv_image
  import ara_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [DATA_W-1:0] nv_offset_in,
  input wire logic nv_adjusted_in,
  input wire logic store,
  input wire logic [DATA_W-1:0] store_offset,
  input wire logic store_adjusted,
  output logic [DATA_W-1:0] offset,
  output logic adjusted,
  output logic loaded
);
  typedef struct packed {
    logic [DATA_W-1:0] offset;
    logic adjusted;
    logic loaded;
  } ara_nv_s;

  ara_nv_s st;
  ara_nv_s next_st;

  always_comb begin
    next_st = st;
    if (!st.loaded) begin
      // image is taken from the backing store once, after reset release
      next_st.offset = nv_offset_in;
      next_st.adjusted = nv_adjusted_in;
      next_st.loaded = 1'b1;
    end else if (store) begin
      next_st.offset = store_offset;
      next_st.adjusted = store_adjusted;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign offset = st.offset;
  assign adjusted = st.adjusted;
  assign loaded = st.loaded;
endmodule

// ===== ara_axis_ref_monitor.sv
// concurrent checks on the referencing block ports
`timescale 1ns/1ps
module ara_axis_ref_monitor
  import ara_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic pready,
  input wire logic set_reference_point_input,
  input wire logic traverse_active,
  input wire logic intermediate_stop,
  input wire logic position_value_valid,
  input wire logic position_correction_trigger,
  input wire logic reference_point_set_flag,
  input wire logic save_adjustment_alarm,
  input wire logic approach_active_mode,
  input wire logic flying_referencing_mode,
  input wire logic use_reference_cam,
  input wire logic zero_mark_distance_coded,
  input wire logic zero_mark_source_valid,
  input wire logic nv_store
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  wire set_ok = (!traverse_active || intermediate_stop) && position_value_valid;
  wire ack_wr = psel && penable && pwrite && paddr == OFS_CTRL && pwdata[CTRL_SAVE_BIT];
  a_set_taken: assert property (
    $rose(set_reference_point_input) && set_ok |=> position_correction_trigger
    && reference_point_set_flag) else $error("set edge not taken");
  a_set_dropped: assert property (
    $rose(set_reference_point_input) && !set_ok |=> !position_correction_trigger)
    else $error("set edge taken while blocked");
  a_trig_single: assert property (
    position_correction_trigger |=> !position_correction_trigger) else $error("long trigger");
  a_mode_excl: assert property (
    flying_referencing_mode |-> !approach_active_mode) else $error("both modes");
  a_cam_approach: assert property (
    use_reference_cam |-> approach_active_mode) else $error("cam outside approach");
  a_zm_coded: assert property (
    zero_mark_distance_coded |=> !zero_mark_source_valid) else $error("coded mark valid");
  a_alarm_hold: assert property (
    save_adjustment_alarm && !ack_wr |=> save_adjustment_alarm) else $error("alarm lost");
  a_store_pulse: assert property (
    nv_store |=> !nv_store) else $error("long store pulse");
  a_ready_once: assert property (
    psel && !penable |=> pready ##1 !pready) else $error("bad ready timing");
  c_set: cover property (position_correction_trigger);
  c_alarm: cover property ($rose(save_adjustment_alarm));
  c_xfer: cover property (psel && penable && pready);
endmodule

bind ara_axis_ref ara_axis_ref_monitor mon (.clock(clock), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .set_reference_point_input(set_reference_point_input), .traverse_active(traverse_active),
  .intermediate_stop(intermediate_stop), .position_value_valid(position_value_valid),
  .position_correction_trigger(position_correction_trigger),
  .reference_point_set_flag(reference_point_set_flag),
  .save_adjustment_alarm(save_adjustment_alarm), .approach_active_mode(approach_active_mode),
  .flying_referencing_mode(flying_referencing_mode), .use_reference_cam(use_reference_cam),
  .zero_mark_distance_coded(zero_mark_distance_coded),
  .zero_mark_source_valid(zero_mark_source_valid), .nv_store(nv_store));

// ===== ara_ctrl_model.sv
// controller model: set request held four cycles, overflow pulses
`timescale 1ns/1ps
module ara_ctrl_model
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic set_req,
  input wire logic ovf_req,
  output logic set_ref,
  output logic overflow
);
  logic [1:0] hold;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hold <= 2'h0;
      set_ref <= 1'b0;
      overflow <= 1'b0;
    end else begin
      overflow <= ovf_req;
      hold <= set_req ? 2'h3 : (hold != 2'h0 ? hold - 2'h1 : 2'h0);
      set_ref <= set_req || hold != 2'h0;
    end
  end
endmodule

// ===== ara_axis_ref_tb.sv
// self-checking bench for the referencing block
`timescale 1ns/1ps
module ara_axis_ref_tb
  import ara_pkg::*;
;
  logic clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, ovf = 0, setr = 0;
  logic [ADDR_W-1:0] paddr = 0;
  logic [DATA_W-1:0] pwdata = 0, prdata, act, spt;
  logic pready, pslverr, ovf_req = 0, set_req = 0, valid = 1, trav = 0, stopd = 0, coded = 0;
  logic trig, flag, alarm, fault, appr, fly, cam, extzm, zmok;
  logic nvst, nva;
  logic [DATA_W-1:0] nvo, corr;
  logic [DATA_W-1:0] nv_off = 0;
  logic nv_adj = 0;
  int err_count = 0, tests_run = 0;
  always #20 clock = ~clock;
  ara_ctrl_model ctl (.clock(clock), .rstn(rstn), .set_req(set_req), .ovf_req(ovf_req),
    .set_ref(setr), .overflow(ovf));
  ara_axis_ref dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .encoder_position(32'h0000_0100), .encoder_overflow(ovf),
    .position_value_valid(valid), .set_reference_point_input(setr),
    .traverse_active(trav), .intermediate_stop(stopd),
    .reference_coordinate_input(32'h0000_0777), .position_setpoint_in(32'h0000_0100),
    .zero_mark_distance_coded(coded), .nv_offset_in(nv_off), .nv_adjusted_in(nv_adj),
    .actual_position_value(act), .position_setpoint(spt), .position_correction_trigger(trig),
    .position_correction_value(corr), .reference_point_set_flag(flag),
    .save_adjustment_alarm(alarm), .reference_outside_range_fault(fault),
    .approach_active_mode(appr), .flying_referencing_mode(fly), .use_reference_cam(cam),
    .use_external_zero_mark(extzm), .zero_mark_source_valid(zmok), .nv_store(nvst),
    .nv_offset_out(nvo), .nv_adjusted_out(nva));
  // backing store keeps its image across resets of the block
  always @(posedge clock) begin
    if (nvst === 1'b1) begin
      nv_off <= nvo;
      nv_adj <= nva;
    end
  end
  task stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task settle();
    repeat (3) @(posedge clock);
    #1;
  endtask
  task xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
            input logic [31:0] ed, input logic ee);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin err_count++; stop_test(); end
    if (!w) check(prdata, ed);
    check(pslverr, ee);
    psel <= 0; penable <= 0;
  endtask
  task set_try(input logic v, input logic tr, input logic st, input logic late,
               input int hits_exp, input logic [31:0] pos);
    int hits;
    hits = 0;
    for (int i = 0; i < 12; i++) begin
      @(posedge clock);
      if (i == 0) begin valid <= v; trav <= tr; stopd <= st; set_req <= 1; end
      if (i == 1) set_req <= 0;
      if (i == 3 && late) valid <= 1;
      #1 hits += (trig === 1'b1);
    end
    check(hits, hits_exp);
    check(act, pos);
    check(spt, pos);
  endtask
  task t_modes();
    xfer(0, OFS_CTRL, 0, 0, 0);
    xfer(0, 8'h40, 0, 0, 1);
    xfer(1, OFS_STATUS, 32'h1, 0, 1);
    xfer(1, OFS_CTRL, 32'h1, 0, 0); settle();
    check({fly, appr}, 2'h2);
    xfer(1, OFS_CTRL, 32'h2, 0, 0); settle();
    check({fly, appr, cam}, 3'h3);
    xfer(1, OFS_CTRL, 32'h0, 0, 0); settle();
    check(cam, 0);
    xfer(1, OFS_ZERO_MARK, 32'h5, 0, 0); settle();
    check(extzm, 1);
    xfer(1, OFS_ZERO_MARK, 32'h0, 0, 0); settle();
    check(extzm, 0);
    @(posedge clock) coded <= 1;
    settle();
    check(zmok, 0);
    @(posedge clock) coded <= 0;
    $display("modes done");
  endtask
  task t_set();
    xfer(1, OFS_COORD_SETTING, 32'h1234, 0, 0);
    set_try(1, 0, 0, 0, 1, 32'h1234);
    check(flag, 1);
    check(corr, 32'h1134);
    xfer(1, OFS_CTRL, 32'h8, 0, 0);
    set_try(1, 1, 1, 0, 1, 32'h777);
    set_try(1, 1, 0, 0, 0, 32'h777);
    set_try(0, 0, 0, 1, 0, 32'h777);
    $display("set done");
  endtask
  task t_adjust();
    xfer(1, OFS_CTRL, 32'h0, 0, 0);
    xfer(1, OFS_COORD_SETTING, 32'h0030_0000, 0, 0);
    xfer(1, OFS_ADJ_CMD, 32'h2, 0, 0); settle();
    xfer(0, OFS_ADJ_CMD, 0, 32'h3, 0);
    check({flag, alarm}, 2'h3);
    check(act, 32'h0030_0000);
    xfer(0, OFS_ADJ_OFFSET, 0, 32'h002F_FF00, 0);
    xfer(1, OFS_CTRL, 32'h20, 0, 0); settle();
    check(alarm, 0);
    for (int k = 0; k < 2; k++) begin
      @(posedge clock) ovf_req <= 1;
      @(posedge clock) ovf_req <= 0;
      settle();
      xfer(0, OFS_ADJ_CMD, 0, k ? 32'h0 : 32'h3, 0);
    end
    check(flag, 0);
    xfer(1, OFS_COORD_SETTING, 32'h0050_0000, 0, 0);
    xfer(1, OFS_ADJ_CMD, 32'h2, 0, 0); settle();
    check(fault, 1);
    xfer(0, OFS_ADJ_CMD, 0, 32'h0, 0);
    xfer(1, OFS_CTRL, 32'h10, 0, 0);
    xfer(1, OFS_ADJ_CMD, 32'h2, 0, 0); settle();
    xfer(0, OFS_ADJ_CMD, 0, 32'h3, 0);
    check(act, 32'h0050_0000);
    $display("adjust done");
  endtask
  task t_power(input logic adj_exp, input logic [31:0] pos);
    @(posedge clock) rstn <= 0;
    repeat (2) @(posedge clock);
    rstn <= 1;
    settle();
    check(flag, adj_exp);
    check(act, pos);
    xfer(0, OFS_ADJ_CMD, 0, adj_exp ? 32'h3 : 32'h0, 0);
  endtask
  task t_restore();
    t_power(1, 32'h0050_0000);
    for (int k = 0; k < 2; k++) begin
      // first pass keeps tracking on while the axis may leave the range; second pass turns it off
      xfer(1, OFS_CTRL, k ? 32'h0 : 32'h4, 0, 0);
      repeat (2) begin
        @(posedge clock) ovf_req <= 1;
        @(posedge clock) ovf_req <= 0;
      end
      repeat (2) settle();
      check(nv_adj, !k);
      xfer(0, OFS_ADJ_CMD, 0, k ? 32'h0 : 32'h3, 0);
    end
    t_power(0, 32'h0050_0000);
    $display("restore done");
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge clock);
    rstn <= 1;
    @(posedge clock);
    t_modes();
    t_set();
    t_adjust();
    t_restore();
    stop_test();
  end
endmodule
